//--- lccd_chk.sv
// checker: apb answers, register shadow, power, duty and sync levels
// assumes it is bound to lccd_top and sees only its ports
`timescale 1ns/1ps
module lccd_chk #(
    parameter CW = 4
) (
    // clock, reset and apb
    input wire        ref_clk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // pins and channel outputs
    input wire        div_clk_in,
    input wire        chip_sync,
    input wire        stage_one_out,
    input wire        channel_out,
    input wire        duty_correction_enable,
    input wire        stage_one_powered,
    input wire        stage_two_powered,
    input wire        next_stage_one_out
);
    reg  [7:0] sh_reg [0:5];                    // shadow of written registers
    reg  [3:0] sync_cnt_reg;                    // cycles that sync has been high
    wire [8:0] off    = paddr[10:2] - 9'h199;   // position in register table
    wire       in_tab = !paddr[11] && (off < 9'd6);
    wire       mapped = in_tab || (!paddr[11] && paddr[10:2] == 9'h1A8);
    wire [7:0] mask   = (off == 9'd3) ? 8'h3F : (off == 9'd4) ? 8'h01 : 8'hFF;
    wire [7:0] ctrl   = sh_reg[3];
    integer    i;
    // follow writes and count how long sync is held
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 6; i = i + 1) sh_reg[i] <= 8'h00;
            sync_cnt_reg <= 4'h0;
        end else begin
            if (psel && penable && pwrite && in_tab) sh_reg[off[2:0]] <= pwdata[7:0] & mask;
            if (!chip_sync) sync_cnt_reg <= 4'h0;
            else if (sync_cnt_reg != 4'hF) sync_cnt_reg <= sync_cnt_reg + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // sync settled in the design and controls steady
    sequence s_held;
        (sync_cnt_reg > 4'd6 && $stable(ctrl)) [*3];
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (psel && !penable |=> pslverr == !$past(mapped))
        else $error("pslverr wrong for address");
    a_read_back: assert property (psel && penable && !pwrite && in_tab |->
        prdata == {24'h0, sh_reg[off[2:0]]}) else $error("read data differs");
    a_bad_zero: assert property (psel && penable && !mapped |-> prdata == 32'h0 && pslverr)
        else $error("unmapped access not refused");
    a_power_flags: assert property (stage_one_powered == !ctrl[4] &&
        stage_two_powered == !ctrl[5]) else $error("power flags wrong");
    a_duty_flag: assert property (duty_correction_enable == !sh_reg[4][0])
        else $error("duty correction flag wrong");
    a_force_level: assert property (s_held |-> channel_out == ctrl[2])
        else $error("forced level wrong");
    a_sync_start: assert property (s_held ##0 !ctrl[3] && !ctrl[4] |->
        stage_one_out == ctrl[0] && !next_stage_one_out) else $error("start level not held");
endmodule // lccd_chk

//--- lccd_defs.vh
// register indices, field positions and reset values of the channel divider
// assumes the including module addresses registers as index * 4 on the bus
`ifndef LCCD_DEFS_VH
`define LCCD_DEFS_VH

// register indices (byte address is four times the index)
`define LCCD_IDX_S1_COUNTS   9'h199
`define LCCD_IDX_PHASE       9'h19A
`define LCCD_IDX_S2_COUNTS   9'h19B
`define LCCD_IDX_CTRL        9'h19C
`define LCCD_IDX_DUTY        9'h19D
`define LCCD_IDX_NEXT_COUNTS 9'h19E
`define LCCD_IDX_STATUS      9'h1A8

// nibble fields of count and phase registers
`define LCCD_UPPER_MSB 7
`define LCCD_UPPER_LSB 4
`define LCCD_LOWER_MSB 3
`define LCCD_LOWER_LSB 0

// control register bits
`define LCCD_BIT_S2_BYPASS  5
`define LCCD_BIT_S1_BYPASS  4
`define LCCD_BIT_IGN_SYNC   3
`define LCCD_BIT_FORCE_HIGH 2
`define LCCD_BIT_S2_START   1
`define LCCD_BIT_S1_START   0

// duty register bit
`define LCCD_BIT_DCC_DIS    0

// reset values
`define LCCD_RST_COUNTS 8'h00
`define LCCD_RST_PHASE  8'h00
`define LCCD_RST_CTRL   8'h00
`define LCCD_RST_DUTY   8'h00

`endif

//--- lccd_stage.v
// one divider stage: counts input clock cycles into low and high periods
// assumes in_rise is a one-cycle pulse on each rising edge of in_level
`timescale 1ns/1ps
module lccd_stage #(
    parameter CW = 4
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // divider input clock, as level and rising-edge pulse
    input  wire          in_level,
    input  wire          in_rise,
    // controls
    input  wire          restart,
    input  wire          bypass,
    input  wire          start_high,
    input  wire [CW-1:0] low_cnt,
    input  wire [CW-1:0] high_cnt,
    input  wire [CW-1:0] phase,
    // stage output, as level and rising-edge pulse
    output reg           out_level,
    output reg           out_rise
);
    reg  [CW:0] cnt_reg;   // input cycles left in present level
    reg         lvl_reg;   // divided level
    wire        out_next;  // next output level

    // bypass routes the input clock straight through
    assign out_next = bypass ? in_level : lvl_reg;

    // counter and level; bypass holds the counter still (powered down)
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= {(CW+1){1'b0}};
            lvl_reg   <= 1'b0;
            out_level <= 1'b0;
            out_rise  <= 1'b0;
        end else begin
            out_level <= out_next;
            out_rise  <= out_next & ~out_level;
            if (bypass || restart) begin
                // first level lengthened by phase input cycles
                lvl_reg <= start_high;
                cnt_reg <= (start_high ? {1'b0, high_cnt} : {1'b0, low_cnt})
                           + {1'b0, phase};
            end else if (in_rise) begin
                if (cnt_reg == {(CW+1){1'b0}}) begin
                    // field value n gives n+1 input cycles per level
                    lvl_reg <= ~lvl_reg;
                    cnt_reg <= lvl_reg ? {1'b0, low_cnt} : {1'b0, high_cnt};
                end else begin
                    cnt_reg <= cnt_reg - {{CW{1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // lccd_stage

//--- lccd_top.v
// channel divider top: apb registers, input synchronisers, two cascaded
// stages of channel 2 and the first stage of channel 3
// assumes div_clk_in is far slower than ref_clk (at most ref_clk / 4)
// assumes chip_sync is a level held for several ref_clk cycles, not a glitch
// assumes the apb master keeps paddr steady from setup to access
// the divider input is oversampled, so every output edge lands on ref_clk
// channel 3 owns only its first stage here; its other controls live elsewhere
//
// Summary of operation
// - stage one low time is field plus one
// - stage one high time is field plus one
// - stage two uses own low, high counts
// - channel three first stage uses its counts
// - zero field gives one cycle; counts reset zero
// - phase offsets per channel 2 stage, reset zero
// - stage two bypass passes input, stops counting
// - stage one bypass passes input, stops counting
// - ignore-sync bit makes channel 2 dividers disregard sync
// - force bit sets forced output level
// - stage two start level from its bit
// - stage one start level from its bit
// - duty correction active unless disable bit set
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "lccd_defs.vh"
module lccd_top #(
    parameter CW = 4
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // divider input clock and chip-level sync pins
    input  wire        div_clk_in,
    input  wire        chip_sync,
    // channel 2 outputs
    output wire        stage_one_out,
    output reg         channel_out,
    output wire        duty_correction_enable,
    output wire        stage_one_powered,
    output wire        stage_two_powered,
    // channel 3 first stage output
    output wire        next_stage_one_out
);
    // reset release
    reg        rst_s1_reg;       // first release flop
    reg        rst_s2_reg;       // released reset used by the design
    wire       rst_n;            // internal active-low reset

    // configuration registers
    // all eight bits wide, carried in the low byte of the bus word
    reg  [7:0] s1_counts_reg;    // stage one low/high counts
    reg  [7:0] phase_reg;        // stage two/one phase offsets
    reg  [7:0] s2_counts_reg;    // stage two low/high counts
    reg  [7:0] ctrl_reg;         // bypass, sync, force, start bits
    reg  [7:0] duty_reg;         // duty correction disable
    reg  [7:0] next_counts_reg;  // channel 3 stage one counts

    // pin synchronisers
    // both pins are asynchronous to ref_clk
    reg  [2:0] clk_sync_reg;     // divider clock pin pipeline
    reg  [2:0] sy_sync_reg;      // sync pin pipeline
    reg        clk_lvl_reg;      // filtered divider clock level
    reg        clk_rise_reg;     // one-cycle pulse on its rising edge
    reg        sync_lvl_reg;     // filtered chip sync level

    // apb decode
    wire       setup_ph;         // setup cycle of a transfer
    wire       wr_en;            // write takes effect
    reg        mapped;           // address hits a register
    reg  [7:0] rd_val;           // selected read value
    wire [8:0] idx;              // register index from address

    // stage wiring
    // each stage reports its level and a one-cycle rising pulse
    wire       s2_out;           // stage two level
    wire       s1_rise;          // stage one rising pulse
    wire       div_hold;         // restart dividers on sync
    wire       ch3_hold;         // restart channel 3 stage on sync
    wire       s1_byp;           // stage one bypass
    wire       s2_byp;           // stage two bypass
    wire       ign_sync;         // ignore-sync bit
    wire       force_lvl;        // forced output level
    wire       forced;           // output held at the forced level
    wire [7:0] status_val;       // live state for the status register

    // reset goes low at once and is released through two flops
    // so every flop on rst_n leaves reset on the same ref_clk edge
    // rst_n feeds every other process of the block
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // three-flop synchronisers; a change counts when flops two and three agree
    // the first flop may go metastable, so only flops two and three are compared
    // a one-cycle disagreement is a glitch and leaves the filtered level alone
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_reg <= 3'h0;
            sy_sync_reg  <= 3'h0;
            clk_lvl_reg  <= 1'b0;
            clk_rise_reg <= 1'b0;
            sync_lvl_reg <= 1'b0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], div_clk_in};
            sy_sync_reg  <= {sy_sync_reg[1:0], chip_sync};
            clk_rise_reg <= 1'b0;
            // divider clock: edge pulse marks one input cycle
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_lvl_reg  <= clk_sync_reg[2];
                clk_rise_reg <= clk_sync_reg[2] & ~clk_lvl_reg;
            end
            // chip sync level
            if (sy_sync_reg[1] == sy_sync_reg[2]) begin
                sync_lvl_reg <= sy_sync_reg[2];
            end
        end
    end

    // control fields
    // bits 7:6 of the control register are not stored and read as zero
    assign s1_byp    = ctrl_reg[`LCCD_BIT_S1_BYPASS];
    assign s2_byp    = ctrl_reg[`LCCD_BIT_S2_BYPASS];
    assign ign_sync  = ctrl_reg[`LCCD_BIT_IGN_SYNC];
    assign force_lvl = ctrl_reg[`LCCD_BIT_FORCE_HIGH];

    // sync restarts the channel 2 dividers unless ignored
    // a held sync keeps restarting them, so all edges line up on release
    assign div_hold = sync_lvl_reg & ~ign_sync;
    // channel 3 has its own ignore bit elsewhere; it always obeys here
    assign ch3_hold = sync_lvl_reg;
    // output takes the force level while sync is asserted
    // software sets ignore-sync too when it relies on the forced level
    assign forced   = sync_lvl_reg;

    // stage one of channel 2, fed by the divider input clock
    // its phase offset only lengthens the first level after a sync restart or a bypass release
    lccd_stage #(
        .CW (CW)
    ) u_stage_one (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .in_level   (clk_lvl_reg),
        .in_rise    (clk_rise_reg),
        .restart    (div_hold),
        .bypass     (s1_byp),
        .start_high (ctrl_reg[`LCCD_BIT_S1_START]),
        .low_cnt    (s1_counts_reg[`LCCD_UPPER_MSB:`LCCD_UPPER_LSB]),
        .high_cnt   (s1_counts_reg[`LCCD_LOWER_MSB:`LCCD_LOWER_LSB]),
        .phase      (phase_reg[`LCCD_LOWER_MSB:`LCCD_LOWER_LSB]),
        .out_level  (stage_one_out),
        .out_rise   (s1_rise)
    );

    // stage two counts cycles of stage one output
    // its input pulse is stage one's registered rising edge, in the same cycle as stage_one_out rises
    lccd_stage #(
        .CW (CW)
    ) u_stage_two (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .in_level   (stage_one_out),
        .in_rise    (s1_rise),
        .restart    (div_hold),
        .bypass     (s2_byp),
        .start_high (ctrl_reg[`LCCD_BIT_S2_START]),
        .low_cnt    (s2_counts_reg[`LCCD_UPPER_MSB:`LCCD_UPPER_LSB]),
        .high_cnt   (s2_counts_reg[`LCCD_LOWER_MSB:`LCCD_LOWER_LSB]),
        .phase      (phase_reg[`LCCD_UPPER_MSB:`LCCD_UPPER_LSB]),
        .out_level  (s2_out),
        .out_rise   ()
    );

    // first stage of channel 3, same input clock
    // no bypass or start-level control of its own in this block
    lccd_stage #(
        .CW (CW)
    ) u_next_stage_one (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .in_level   (clk_lvl_reg),
        .in_rise    (clk_rise_reg),
        .restart    (ch3_hold),
        .bypass     (1'b0),
        .start_high (1'b0),
        .low_cnt    (next_counts_reg[`LCCD_UPPER_MSB:`LCCD_UPPER_LSB]),
        .high_cnt   (next_counts_reg[`LCCD_LOWER_MSB:`LCCD_LOWER_LSB]),
        .phase      ({CW{1'b0}}),
        .out_level  (next_stage_one_out),
        .out_rise   ()
    );

    // channel output: forced level during sync, else the cascade result
    // registered so the pin sees no glitch when force and cascade swap
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_out <= 1'b0;
        end else if (forced) begin
            channel_out <= force_lvl;
        end else begin
            channel_out <= s2_out;
        end
    end

    // power and duty-correction levels to the output drivers
    // the analog drivers gate their supply from these levels
    assign stage_one_powered      = ~s1_byp;
    assign stage_two_powered      = ~s2_byp;
    assign duty_correction_enable = ~duty_reg[`LCCD_BIT_DCC_DIS];

    // live state for software
    assign status_val = {
        4'h0,            // reserved, reads zero
        sync_lvl_reg,    // bit 3: synchronised sync level
        channel_out,     // bit 2: channel output
        s2_out,          // bit 1: stage two level
        stage_one_out    // bit 0: stage one level
    };

    // apb: zero wait states
    // every transfer completes in its first access cycle, so no wait logic
    // address bit 11 selects the upper half, which holds no register
    assign pready   = 1'b1;
    assign idx      = paddr[10:2];
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & mapped;

    // address decode and read mux
    // an index outside the table clears mapped and reads as zero
    always @* begin
        mapped = ~paddr[11];
        rd_val = 8'h00;
        case (idx)
            `LCCD_IDX_S1_COUNTS:   rd_val = s1_counts_reg;
            `LCCD_IDX_PHASE:       rd_val = phase_reg;
            `LCCD_IDX_S2_COUNTS:   rd_val = s2_counts_reg;
            `LCCD_IDX_CTRL:        rd_val = ctrl_reg;
            `LCCD_IDX_DUTY:        rd_val = duty_reg;
            `LCCD_IDX_NEXT_COUNTS: rd_val = next_counts_reg;
            `LCCD_IDX_STATUS:      rd_val = status_val;
            default:               mapped = 1'b0;
        endcase
    end

    // read data and error are latched in the setup cycle
    // latching at setup keeps prdata steady through the access phase
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            if (mapped && !pwrite) begin
                prdata <= {24'h000000, rd_val}; // mapped read
            end else begin
                prdata <= 32'h00000000;         // write or refused access
            end
            pslverr <= ~mapped;
        end
    end

    // register writes at the access edge; status is read-only
    // reserved bits are dropped, so they always read back as zero
    // a new count applies at the next level reload, not at once
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_counts_reg   <= `LCCD_RST_COUNTS;
            phase_reg       <= `LCCD_RST_PHASE;
            s2_counts_reg   <= `LCCD_RST_COUNTS;
            ctrl_reg        <= `LCCD_RST_CTRL;
            duty_reg        <= `LCCD_RST_DUTY;
            next_counts_reg <= `LCCD_RST_COUNTS;
        end else if (wr_en) begin
            case (idx)
                `LCCD_IDX_S1_COUNTS:   s1_counts_reg   <= pwdata[7:0];
                `LCCD_IDX_PHASE:       phase_reg       <= pwdata[7:0];
                `LCCD_IDX_S2_COUNTS:   s2_counts_reg   <= pwdata[7:0];
                // control keeps bypass, sync, force and start bits 5:0
                `LCCD_IDX_CTRL:        ctrl_reg        <= {2'b00, pwdata[5:0]};
                // duty register keeps only the disable bit
                `LCCD_IDX_DUTY:        duty_reg        <= {7'h00, pwdata[0]};
                `LCCD_IDX_NEXT_COUNTS: next_counts_reg <= pwdata[7:0];
                default: begin
                    // status and unmapped: nothing stored
                end
            endcase
        end
    end
endmodule // lccd_top

//--- lvds_cmos_channel_divider_tb.sv
// self-checking bench of the channel divider over apb
// assumes lccd_top and lccd_chk are compiled before it
`timescale 1ns/1ps
module lvds_cmos_channel_divider_tb;
    localparam CW = 4;
    // stimulus
    reg         ref_clk    = 1'b0;
    reg         reset_n    = 1'b0;
    reg         psel       = 1'b0;
    reg         penable    = 1'b0;
    reg         pwrite     = 1'b0;
    reg  [11:0] paddr      = 12'h000;
    reg  [31:0] pwdata     = 32'h0;
    reg         div_clk_in = 1'b0;
    reg         chip_sync  = 1'b0;
    // design outputs
    wire [31:0] prdata;
    wire        pready, pslverr, s1_out, ch_out, dce, s1_pwr, s2_pwr, s3_out;
    integer     n_fail = 0, num_checks = 0, cyc = 0, dcnt = 0, hi, lo, i;
    reg  [31:0] rd;
    reg         err;
    // 10 mhz reference clock
    always #50 ref_clk = ~ref_clk;
    // divider input of 8 reference cycles, and the run limit
    always @(posedge ref_clk) begin
        dcnt       <= dcnt + 1;
        div_clk_in <= dcnt[2];
        cyc        <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    lccd_top #(.CW(CW)) u_lccd_top (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .div_clk_in(div_clk_in),
        .chip_sync(chip_sync), .stage_one_out(s1_out), .channel_out(ch_out),
        .duty_correction_enable(dce), .stage_one_powered(s1_pwr),
        .stage_two_powered(s2_pwr), .next_stage_one_out(s3_out)
    );
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input w, input [11:0] a, input [31:0] wd);
        begin
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= wd;
            penable <= 1'b0;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) @(posedge ref_clk);
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task wr(input [8:0] idx, input [31:0] v);
        apb(1'b1, {1'b0, idx, 2'b00}, v);
    endtask
    task rdc(input [8:0] idx, input [31:0] exp, input e);
        begin
            apb(1'b0, {1'b0, idx, 2'b00}, 32'h0);
            chk(rd, exp);
            chk(err, e);
        end
    endtask
    function sig(input integer s);
        sig = (s == 0) ? s1_out : (s == 1) ? ch_out : s3_out;
    endfunction
    // high and low time in reference cycles, second whole period
    task mchk(input integer s, input integer eh, input integer el);
        integer k, r;
        begin
            for (r = 0; r < 2; r = r + 1) begin
                hi = 0;
                lo = 0;
                for (k = 0; k < 3000 && sig(s) !== 1'b0; k = k + 1) @(posedge ref_clk);
                for (k = 0; k < 3000 && sig(s) !== 1'b1; k = k + 1) @(posedge ref_clk);
                while (sig(s) === 1'b1 && hi < 3000) begin
                    hi = hi + 1;
                    @(posedge ref_clk);
                end
                while (sig(s) === 1'b0 && lo < 3000) begin
                    lo = lo + 1;
                    @(posedge ref_clk);
                end
            end
            chk(hi, eh);
            chk(lo, el);
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (i = 0; i < 6; i = i + 1) rdc(9'h199 + i[8:0], 32'h0, 1'b0);
        mchk(0, 8, 8);
        mchk(1, 16, 16);
        mchk(2, 8, 8);
        wr(9'h199, 32'h21);
        wr(9'h19B, 32'h10);
        wr(9'h19E, 32'h03);
        wr(9'h19A, 32'hFFFFFF2A);
        rdc(9'h19A, 32'h2A, 1'b0);
        mchk(0, 16, 24);
        mchk(1, 40, 80);
        mchk(2, 32, 8);
        // bypass each stage in turn
        wr(9'h19C, 32'h10);
        chk(s1_pwr, 1'b0);
        mchk(0, 4, 4);
        mchk(1, 8, 16);
        wr(9'h19C, 32'h20);
        chk(s2_pwr, 1'b0);
        mchk(1, 16, 24);
        wr(9'h19C, 32'h30);
        mchk(1, 4, 4);
        // forced level with sync ignored, dividers keep running
        wr(9'h19C, 32'hCC);
        rdc(9'h19C, 32'h0C, 1'b0);
        chip_sync <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk(ch_out, 1'b1);
        mchk(0, 16, 24);
        wr(9'h19C, 32'h08);
        repeat (3) @(posedge ref_clk);
        chk(ch_out, 1'b0);
        // sync obeyed: start levels held
        wr(9'h19C, 32'h03);
        repeat (3) @(posedge ref_clk);
        rdc(9'h1A8, 32'h0B, 1'b0);
        wr(9'h19C, 32'h00);
        repeat (3) @(posedge ref_clk);
        rdc(9'h1A8, 32'h08, 1'b0);
        chip_sync <= 1'b0;
        // duty correction control
        wr(9'h19D, 32'hFF);
        rdc(9'h19D, 32'h01, 1'b0);
        chk(dce, 1'b0);
        wr(9'h19D, 32'h00);
        chk(dce, 1'b1);
        // unmapped places are refused
        rdc(9'h19F, 32'h0, 1'b1);
        apb(1'b0, 12'h800, 32'h0);
        chk(err, 1'b1);
        final_report;
    end
endmodule // lvds_cmos_channel_divider_tb
bind lccd_top lccd_chk #(.CW(CW)) u_lccd_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .div_clk_in(div_clk_in),
    .chip_sync(chip_sync), .stage_one_out(stage_one_out), .channel_out(channel_out),
    .duty_correction_enable(duty_correction_enable),
    .stage_one_powered(stage_one_powered), .stage_two_powered(stage_two_powered),
    .next_stage_one_out(next_stage_one_out)
);
